// ===== common/ebct_consts.vh
`ifndef EBCT_CONSTS_VH
`define EBCT_CONSTS_VH

// apb address width; a register index times four is its byte address
`define EBCT_ADDR_W        18
`define EBCT_IDX_W         16
`define EBCT_IDX_CTRL0     16'hFFA0
`define EBCT_IDX_CSR       16'hFFA1
`define EBCT_IDX_CTRL1     16'hFFA5
`define EBCT_IDX_COUNT     16'hFFA8
`define EBCT_IDX_CMPA      16'hFFA9
`define EBCT_IDX_CMPB      16'hFFAA
`define EBCT_IDX_IRQ       16'hFFAB

// timer_control_zero fields
`define EBCT_C0_MIEB       7
`define EBCT_C0_MIEA       6
`define EBCT_C0_OVERFLOW_IRQ_ENABLE       5
`define EBCT_C0_CCLR_HI    4
`define EBCT_C0_CCLR_LO    3
`define EBCT_C0_CKS_HI     2
`define EBCT_C0_CKS_LO     0

// timer_control_status fields (also the irq status layout)
`define EBCT_CS_FLAG_B     7
`define EBCT_CS_FLAG_A     6
`define EBCT_CS_OVF        5
`define EBCT_CS_OSB_HI     3
`define EBCT_CS_OSB_LO     2
`define EBCT_CS_OSA_HI     1
`define EBCT_CS_OSA_LO     0
`define EBCT_CS_WMASK      8'h0F

// timer_control_one fields
`define EBCT_C1_TEDGE_HI   4
`define EBCT_C1_TEDGE_LO   3
`define EBCT_C1_TRIGGER_INPUT_ENABLE       2
`define EBCT_C1_ICKS       0
`define EBCT_C1_WMASK      8'h1D

// counter clear selection
`define EBCT_CCLR_NONE     2'h0
`define EBCT_CCLR_MATCH_A  2'h1
`define EBCT_CCLR_MATCH_B  2'h2
`define EBCT_CCLR_TRIG     2'h3

// trigger edge selection
`define EBCT_EDGE_NONE     2'h0
`define EBCT_EDGE_RISE     2'h1
`define EBCT_EDGE_FALL     2'h2
`define EBCT_EDGE_BOTH     2'h3

// output action on a match
`define EBCT_OUT_KEEP      2'h0
`define EBCT_OUT_LOW       2'h1
`define EBCT_OUT_HIGH      2'h2
`define EBCT_OUT_TOGGLE    2'h3

// clock select codes
`define EBCT_CKS_STOP      3'h0
`define EBCT_CKS_DIV4_8    3'h1
`define EBCT_CKS_DIV16_32  3'h2
`define EBCT_CKS_DIV64_128 3'h3

// prescaler: tap k ticks once every 2^(k+1) system clocks
`define EBCT_PRE_W         7
`define EBCT_TAP_DIV4      1
`define EBCT_TAP_DIV8      2
`define EBCT_TAP_DIV16     3
`define EBCT_TAP_DIV32     4
`define EBCT_TAP_DIV64     5
`define EBCT_TAP_DIV128    6

// reset values
`define EBCT_RST_CTRL0     8'h00
`define EBCT_RST_CSR       8'h00
`define EBCT_RST_CTRL1     8'h00
`define EBCT_RST_COUNT     8'h00
`define EBCT_RST_CMP       8'hFF
`define EBCT_RST_PRE       7'h00
`define EBCT_RST_PIN       1'b0

`define EBCT_COUNT_MAX     8'hFF
`define EBCT_COUNT_ONE     8'h01
`define EBCT_ZERO8         8'h00

`endif

// ===== src/ebct_prescaler.v
`timescale 1ns/1ps
`include "ebct_consts.vh"

module ebct_prescaler (
	// clock and reset
	input  wire                     sys_clk_i,
	input  wire                     reset_n_i,
	// one-cycle ticks, one per divided falling edge
	output wire [`EBCT_PRE_W-1:0]   tick_o
);

	reg  [`EBCT_PRE_W-1:0] cnt_q;
	reg  [`EBCT_PRE_W-1:0] tick_q;
	reg  [`EBCT_PRE_W-1:0] tick_d;
	integer                k;

	// tick k fires in the same cycle that bit k of the divider falls
	always @* begin
		tick_d = `EBCT_RST_PRE;
		for (k = 0; k < `EBCT_PRE_W; k = k + 1) begin
			tick_d[k] = &(cnt_q | ~(({`EBCT_PRE_W{1'b1}} >> (`EBCT_PRE_W - 1 - k))));
		end
	end

	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q  <= `EBCT_RST_PRE;
			tick_q <= `EBCT_RST_PRE;
		end else begin
			cnt_q  <= cnt_q + 7'h01;
			tick_q <= tick_d;
		end
	end

	assign tick_o = tick_q;

endmodule // ebct_prescaler

// ===== src/ebct_timer.v
`timescale 1ns/1ps
`include "ebct_consts.vh"

module ebct_timer (
	// clock and reset
	input  wire                     sys_clk_i,
	input  wire                     reset_n_i,
	// apb slave
	input  wire                     psel_i,
	input  wire                     penable_i,
	input  wire                     pwrite_i,
	input  wire [`EBCT_ADDR_W-1:0]  paddr_i,
	input  wire [31:0]              pwdata_i,
	output wire                     pready_o,
	output wire [31:0]              prdata_o,
	output wire                     pslverr_o,
	// pins
	input  wire                     trigger_input_pin_i,
	output wire                     timer_output_pin_o,
	// interrupt
	output wire                     irq_o
);

	////////////////////////////////////////////////////////////////////////////////
	// functions

	function is_reg;
		input [`EBCT_ADDR_W-1:0] addr;
		input [`EBCT_IDX_W-1:0]  idx;
		begin
			is_reg = (addr == {idx, 2'b00});
		end
	endfunction

	function out_next;
		input       cur;
		input [1:0] sel;
		begin
			case (sel)
				`EBCT_OUT_LOW:    out_next = 1'b0;
				`EBCT_OUT_HIGH:   out_next = 1'b1;
				`EBCT_OUT_TOGGLE: out_next = ~cur;
				default:          out_next = cur;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	reg  [7:0]              ctrl0_q;
	reg  [7:0]              csr_q;
	reg  [7:0]              ctrl1_q;
	reg  [7:0]              count_q;
	reg  [7:0]              count_d;
	reg  [7:0]              cmpa_q;
	reg  [7:0]              cmpb_q;
	reg                     flag_a_q;
	reg                     flag_b_q;
	reg                     ovf_q;
	reg                     flag_a_d;
	reg                     flag_b_d;
	reg                     ovf_d;
	reg                     armed_a_q;
	reg                     armed_b_q;
	reg                     armed_ovf_q;
	reg                     pin_q;
	reg                     pin_d;
	reg                     trig_s1_q;
	reg                     trig_s2_q;
	reg                     trig_s3_q;
	reg  [31:0]             prdata_q;
	reg  [31:0]             rdata_d;
	reg                     pslverr_q;
	reg                     mapped;
	reg                     tick_sel;
	reg                     trig_edge;
	reg                     count_ev;
	reg                     clear_ev;
	reg                     wrap_ev;
	reg                     upd;
	wire [`EBCT_PRE_W-1:0]  tick;
	wire                    setup;
	wire                    acc;
	wire                    wr;
	wire                    rd;
	wire [7:0]              wd;
	wire [2:0]              cks;
	wire [1:0]              cclr;
	wire [1:0]              tedge;
	wire                    trigger_input_enable;
	wire                    icks;
	wire [7:0]              status;

	assign cks    = ctrl0_q[`EBCT_C0_CKS_HI:`EBCT_C0_CKS_LO];
	assign cclr   = {ctrl0_q[`EBCT_C0_CCLR_HI], ctrl0_q[`EBCT_C0_CCLR_LO]};
	assign tedge  = ctrl1_q[`EBCT_C1_TEDGE_HI:`EBCT_C1_TEDGE_LO];
	assign trigger_input_enable   = ctrl1_q[`EBCT_C1_TRIGGER_INPUT_ENABLE];
	assign icks   = ctrl1_q[`EBCT_C1_ICKS];
	assign status = {flag_b_q, flag_a_q, ovf_q, 5'h00};

	////////////////////////////////////////////////////////////////////////////////
	// apb framing: data is sampled in setup, so access always completes at once

	// an unmapped setup latches the error flag, which also blocks the write in access
	assign setup     = psel_i & ~penable_i;
	assign acc       = psel_i & penable_i;
	assign wr        = acc & pwrite_i & ~pslverr_q;
	assign rd        = acc & ~pwrite_i & ~pslverr_q;
	assign wd        = pwdata_i[7:0];
	assign pready_o  = 1'b1;
	assign prdata_o  = prdata_q;
	assign pslverr_o = pslverr_q & acc;

	always @* begin
		mapped  = 1'b1;
		rdata_d = 32'h0000_0000;
		if (is_reg(paddr_i, `EBCT_IDX_CTRL0))
			rdata_d[7:0] = ctrl0_q;
		else if (is_reg(paddr_i, `EBCT_IDX_CSR))
			rdata_d[7:0] = status | (csr_q & `EBCT_CS_WMASK);
		else if (is_reg(paddr_i, `EBCT_IDX_CTRL1))
			rdata_d[7:0] = ctrl1_q & `EBCT_C1_WMASK;
		else if (is_reg(paddr_i, `EBCT_IDX_COUNT))
			rdata_d[7:0] = count_q;
		else if (is_reg(paddr_i, `EBCT_IDX_CMPA))
			rdata_d[7:0] = cmpa_q;
		else if (is_reg(paddr_i, `EBCT_IDX_CMPB))
			rdata_d[7:0] = cmpb_q;
		else if (is_reg(paddr_i, `EBCT_IDX_IRQ))
			rdata_d[7:0] = status;
		else
			mapped = 1'b0;
	end

	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q  <= pwrite_i ? 32'h0000_0000 : rdata_d;
			pslverr_q <= ~mapped;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// trigger pin: two-stage synchroniser, third stage for the edge detector
	// a pin pulse shorter than one clock can be lost; meant for slow triggers

	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
			trig_s3_q <= 1'b0;
		end else begin
			trig_s1_q <= trigger_input_pin_i;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q;
		end
	end

	always @* begin
		case (tedge)
			`EBCT_EDGE_RISE: trig_edge = trig_s2_q & ~trig_s3_q;
			`EBCT_EDGE_FALL: trig_edge = ~trig_s2_q & trig_s3_q;
			`EBCT_EDGE_BOTH: trig_edge = trig_s2_q ^ trig_s3_q;
			default:         trig_edge = 1'b0;
		endcase
		trig_edge = trig_edge & trigger_input_enable;
	end

	////////////////////////////////////////////////////////////////////////////////
	// count source

	// the divider runs free, so the first tick after a clock change comes early by up to one period
	ebct_prescaler u_pre (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.tick_o    (tick)
	);

	always @* begin
		case (cks)
			`EBCT_CKS_DIV4_8:    tick_sel = icks ? tick[`EBCT_TAP_DIV8]   : tick[`EBCT_TAP_DIV4];
			`EBCT_CKS_DIV16_32:  tick_sel = icks ? tick[`EBCT_TAP_DIV32]  : tick[`EBCT_TAP_DIV16];
			`EBCT_CKS_DIV64_128: tick_sel = icks ? tick[`EBCT_TAP_DIV128] : tick[`EBCT_TAP_DIV64];
			default:             tick_sel = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// counter: clear beats increment, a software write beats both

	always @* begin
		// a tick and a trigger edge in one cycle count once, not twice
		count_ev = tick_sel | trig_edge;
		case (cclr)
			`EBCT_CCLR_MATCH_A: clear_ev = count_ev & (count_q == cmpa_q);
			`EBCT_CCLR_MATCH_B: clear_ev = count_ev & (count_q == cmpb_q);
			`EBCT_CCLR_TRIG:    clear_ev = trig_edge;
			default:            clear_ev = 1'b0;
		endcase
		wrap_ev = count_ev & ~clear_ev & (count_q == `EBCT_COUNT_MAX);
		upd     = 1'b1;
		if (wr && is_reg(paddr_i, `EBCT_IDX_COUNT))
			count_d = wd;
		else if (clear_ev)
			count_d = `EBCT_ZERO8;
		else if (count_ev)
			count_d = count_q + `EBCT_COUNT_ONE;
		else begin
			count_d = count_q;
			upd     = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// flags: a match is taken when the counter moves onto the compare value

	always @* begin
		flag_a_d = flag_a_q;
		flag_b_d = flag_b_q;
		ovf_d    = ovf_q;
		// zero write after a read as one clears; a write of one is ignored
		if (wr && is_reg(paddr_i, `EBCT_IDX_CSR)) begin
			if (armed_a_q && !wd[`EBCT_CS_FLAG_A])
				flag_a_d = 1'b0;
			if (armed_b_q && !wd[`EBCT_CS_FLAG_B])
				flag_b_d = 1'b0;
			if (armed_ovf_q && !wd[`EBCT_CS_OVF])
				ovf_d = 1'b0;
		end
		if (wr && is_reg(paddr_i, `EBCT_IDX_IRQ)) begin
			if (wd[`EBCT_CS_FLAG_A])
				flag_a_d = 1'b0;
			if (wd[`EBCT_CS_FLAG_B])
				flag_b_d = 1'b0;
			// overflow is left set here: it clears only by the read-then-zero path
		end
		// hardware set wins over any clear in the same cycle
		if (upd && count_d == cmpa_q)
			flag_a_d = 1'b1;
		if (upd && count_d == cmpb_q)
			flag_b_d = 1'b1;
		if (wrap_ev)
			ovf_d = 1'b1;
	end

	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flag_a_q    <= 1'b0;
			flag_b_q    <= 1'b0;
			ovf_q       <= 1'b0;
			armed_a_q   <= 1'b0;
			armed_b_q   <= 1'b0;
			armed_ovf_q <= 1'b0;
		end else begin
			flag_a_q <= flag_a_d;
			flag_b_q <= flag_b_d;
			ovf_q    <= ovf_d;
			// arm on a read that saw the flag set; any csr write disarms
			// other register traffic leaves a pending arm in place
			if (rd && is_reg(paddr_i, `EBCT_IDX_CSR)) begin
				armed_a_q   <= prdata_q[`EBCT_CS_FLAG_A];
				armed_b_q   <= prdata_q[`EBCT_CS_FLAG_B];
				armed_ovf_q <= prdata_q[`EBCT_CS_OVF];
			end else if (wr && is_reg(paddr_i, `EBCT_IDX_CSR)) begin
				armed_a_q   <= 1'b0;
				armed_b_q   <= 1'b0;
				armed_ovf_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output pin: on a coincident match, B acts after A on A's result, so any B action but keep wins

	always @* begin
		pin_d = pin_q;
		if (upd && count_d == cmpa_q)
			pin_d = out_next(pin_d, csr_q[`EBCT_CS_OSA_HI:`EBCT_CS_OSA_LO]);
		if (upd && count_d == cmpb_q)
			pin_d = out_next(pin_d, csr_q[`EBCT_CS_OSB_HI:`EBCT_CS_OSB_LO]);
	end

	////////////////////////////////////////////////////////////////////////////////
	// software registers

	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl0_q <= `EBCT_RST_CTRL0;
			csr_q   <= `EBCT_RST_CSR;
			ctrl1_q <= `EBCT_RST_CTRL1;
			count_q <= `EBCT_RST_COUNT;
			cmpa_q  <= `EBCT_RST_CMP;
			cmpb_q  <= `EBCT_RST_CMP;
			pin_q   <= `EBCT_RST_PIN;
		end else begin
			count_q <= count_d;
			pin_q   <= pin_d;
			if (wr) begin
				if (is_reg(paddr_i, `EBCT_IDX_CTRL0))
					ctrl0_q <= wd;
				if (is_reg(paddr_i, `EBCT_IDX_CSR))
					csr_q <= wd & `EBCT_CS_WMASK;
				if (is_reg(paddr_i, `EBCT_IDX_CTRL1))
					ctrl1_q <= wd & `EBCT_C1_WMASK;
				if (is_reg(paddr_i, `EBCT_IDX_CMPA))
					cmpa_q <= wd;
				if (is_reg(paddr_i, `EBCT_IDX_CMPB))
					cmpb_q <= wd;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt: a level, so it falls as soon as the flag is cleared
	// no edge memory: a flag cleared and set again in one cycle keeps the line high

	assign irq_o = (flag_b_q & ctrl0_q[`EBCT_C0_MIEB])
	             | (flag_a_q & ctrl0_q[`EBCT_C0_MIEA])
	             | (ovf_q    & ctrl0_q[`EBCT_C0_OVERFLOW_IRQ_ENABLE]);

	assign timer_output_pin_o = pin_q;

endmodule // ebct_timer

// ===== test/ebct_timer_monitor.sv
`timescale 1ns/1ps
`include "ebct_consts.vh"

module ebct_timer_monitor (
	// clock and reset
	input  wire                     sys_clk_i,
	input  wire                     reset_n_i,
	// apb
	input  wire                     psel_i,
	input  wire                     penable_i,
	input  wire                     pwrite_i,
	input  wire [`EBCT_ADDR_W-1:0]  paddr_i,
	input  wire [31:0]              pwdata_i,
	input  wire                     pready_o,
	input  wire [31:0]              prdata_o,
	input  wire                     pslverr_o,
	// pins and interrupt
	input  wire                     trigger_input_pin_i,
	input  wire                     timer_output_pin_o,
	input  wire                     irq_o
);
	wire [`EBCT_IDX_W-1:0] idx = paddr_i[`EBCT_ADDR_W-1:2];
	wire                   acc = psel_i && penable_i;
	wire                   rdx = acc && !pwrite_i;
	// misaligned byte addresses count as unmapped
	wire mapped = (paddr_i[1:0] == 2'h0) && (idx == `EBCT_IDX_CTRL0 || idx == `EBCT_IDX_CSR ||
		idx == `EBCT_IDX_CTRL1 || (idx >= `EBCT_IDX_COUNT && idx <= `EBCT_IDX_IRQ));

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	////////////////////////////////////////////////////////////////
	a_ready_high: assert property (pready_o)
		else $error("pready low");
	a_err_unmapped: assert property (acc && !mapped |-> pslverr_o)
		else $error("no error on unmapped access");
	a_err_only_bad: assert property (pslverr_o |-> acc && !mapped)
		else $error("error outside unmapped access");
	a_bad_read_zero: assert property (rdx && !mapped |-> prdata_o == 32'h00000000)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (acc |=> $stable(prdata_o))
		else $error("read data moved after access");
	a_rdata_narrow: assert property (prdata_o[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_csr_resv_zero: assert property (rdx && mapped && idx == `EBCT_IDX_CSR |-> !prdata_o[4])
		else $error("status reserved bit set");
	a_ctrl1_resv_zero: assert property (rdx && mapped && idx == `EBCT_IDX_CTRL1 |->
		prdata_o[7:5] == 3'h0 && !prdata_o[1])
		else $error("control one reserved bits set");
	a_irq_masked_off: assert property (
		acc && pwrite_i && mapped && idx == `EBCT_IDX_CTRL0 && pwdata_i[7:5] == 3'h0 |=> !irq_o)
		else $error("interrupt high with all enables off");

	c_err: cover property (acc && pslverr_o);
	c_irq: cover property ($rose(irq_o));
	c_pin_up: cover property ($rose(timer_output_pin_o));
	c_pin_down: cover property ($fell(timer_output_pin_o));
endmodule // ebct_timer_monitor

bind ebct_timer ebct_timer_monitor i_mon (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
	.prdata_o(prdata_o), .pslverr_o(pslverr_o), .trigger_input_pin_i(trigger_input_pin_i),
	.timer_output_pin_o(timer_output_pin_o), .irq_o(irq_o));

// ===== test/tb.sv
`timescale 1ns/1ps
`include "ebct_consts.vh"

module tb;
	reg                      sys_clk_i;
	reg                      reset_n_i;
	reg                      psel_i;
	reg                      penable_i;
	reg                      pwrite_i;
	reg  [`EBCT_ADDR_W-1:0]  paddr_i;
	reg  [31:0]              pwdata_i;
	reg                      trigger_input_pin_i;
	wire                     pready_o;
	wire [31:0]              prdata_o;
	wire                     pslverr_o;
	wire                     timer_output_pin_o;
	wire                     irq_o;
	integer                  failures;
	integer                  checks;
	integer                  i;
	reg  [7:0]               rd;

	ebct_timer i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
		.pslverr_o(pslverr_o), .trigger_input_pin_i(trigger_input_pin_i),
		.timer_output_pin_o(timer_output_pin_o), .irq_o(irq_o));

	////////////////////////////////////////////////////////////////
	task tally_and_finish;
		begin
			$display("checks %0d failures %0d", checks, failures);
			if (failures == 0 && checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask

	task chk(input string nm, input [7:0] seen, input [7:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask

	task wt(input integer n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	// entered just after an edge; ends one idle cycle later so calls never collide
	task apb(input w, input [`EBCT_ADDR_W-1:0] ad, input [7:0] d);
		integer n;
		begin
			psel_i <= 1'b1;
			pwrite_i <= w;
			paddr_i <= ad;
			pwdata_i <= {24'h000000, d};
			@(posedge sys_clk_i);
			penable_i <= 1'b1;
			n = 0;
			do begin
				@(posedge sys_clk_i);
				n = n + 1;
			end while (pready_o !== 1'b1 && n < 50);
			if (n >= 50) begin
				failures = failures + 1;
				tally_and_finish;
			end
			rd = prdata_o[7:0];
			psel_i <= 1'b0;
			penable_i <= 1'b0;
			@(posedge sys_clk_i);
		end
	endtask

	task wr(input [15:0] x, input [7:0] d);
		apb(1'b1, {x, 2'h0}, d);
	endtask

	task rdc(input string nm, input [15:0] x, input [7:0] e);
		begin
			apb(1'b0, {x, 2'h0}, 8'h00);
			chk(nm, rd, e);
		end
	endtask

	////////////////////////////////////////////////////////////////
	task t_reset;
		begin
			rdc("ctrl0", `EBCT_IDX_CTRL0, `EBCT_RST_CTRL0);
			rdc("csr", `EBCT_IDX_CSR, `EBCT_RST_CSR);
			rdc("ctrl1", `EBCT_IDX_CTRL1, `EBCT_RST_CTRL1);
			rdc("count", `EBCT_IDX_COUNT, `EBCT_RST_COUNT);
			rdc("cmpa", `EBCT_IDX_CMPA, `EBCT_RST_CMP);
			rdc("cmpb", `EBCT_IDX_CMPB, `EBCT_RST_CMP);
			rdc("irq status", `EBCT_IDX_IRQ, 8'h00);
			wr(16'hFFA2, 8'hFF);
			rdc("unmapped", 16'hFFA2, 8'h00);
			apb(1'b0, {`EBCT_IDX_CTRL0, 2'h1}, 8'h00);
			chk("misaligned", rd, 8'h00);
			rdc("ctrl0 kept", `EBCT_IDX_CTRL0, 8'h00);
			wr(`EBCT_IDX_CTRL1, 8'hFF);
			rdc("ctrl1 mask", `EBCT_IDX_CTRL1, `EBCT_C1_WMASK);
			wr(`EBCT_IDX_CSR, 8'hFF);
			rdc("csr mask", `EBCT_IDX_CSR, `EBCT_CS_WMASK);
			wr(`EBCT_IDX_CTRL1, 8'h00);
			wr(`EBCT_IDX_CSR, 8'h00);
		end
	endtask

	task t_flags;
		begin
			wr(`EBCT_IDX_CMPA, 8'h10);
			wr(`EBCT_IDX_CMPB, 8'h20);
			wr(`EBCT_IDX_COUNT, 8'h00);
			wr(`EBCT_IDX_CTRL0, 8'h01);
			wt(150);
			wr(`EBCT_IDX_CTRL0, 8'h00);
			apb(1'b0, {`EBCT_IDX_COUNT, 2'h0}, 8'h00);
			chk("no clear", {7'h00, rd > 8'h20}, 8'h01);
			rdc("match flags", `EBCT_IDX_CSR, 8'hC0);
			chk("irq masked", {7'h00, irq_o}, 8'h00);
			wr(`EBCT_IDX_CTRL0, 8'hC0);
			chk("irq enabled", {7'h00, irq_o}, 8'h01);
			wr(`EBCT_IDX_CSR, 8'h00);
			chk("irq cleared", {7'h00, irq_o}, 8'h00);
			rdc("flags cleared", `EBCT_IDX_CSR, 8'h00);
			wr(`EBCT_IDX_CMPA, 8'h03);
			wr(`EBCT_IDX_COUNT, 8'h00);
			wr(`EBCT_IDX_CTRL0, 8'h09);
			wt(100);
			wr(`EBCT_IDX_CTRL0, 8'h00);
			apb(1'b0, {`EBCT_IDX_COUNT, 2'h0}, 8'h00);
			chk("clear on a", {7'h00, rd <= 8'h03}, 8'h01);
			wr(`EBCT_IDX_IRQ, 8'hFF);
			wr(`EBCT_IDX_CMPB, 8'h05);
			wr(`EBCT_IDX_COUNT, 8'h00);
			wr(`EBCT_IDX_CTRL0, 8'h12);
			wt(300);
			wr(`EBCT_IDX_CTRL0, 8'h00);
			apb(1'b0, {`EBCT_IDX_COUNT, 2'h0}, 8'h00);
			chk("clear on b", {7'h00, rd <= 8'h05}, 8'h01);
			rdc("flags b", `EBCT_IDX_IRQ, 8'hC0);
			wr(`EBCT_IDX_IRQ, 8'hFF);
		end
	endtask

	task t_ovf;
		integer n;
		begin
			wr(`EBCT_IDX_COUNT, 8'hFC);
			wr(`EBCT_IDX_CTRL0, 8'h21);
			n = 0;
			while (irq_o !== 1'b1 && n < 60) begin
				@(posedge sys_clk_i);
				n = n + 1;
			end
			if (n >= 60) begin
				failures = failures + 1;
				tally_and_finish;
			end
			wr(`EBCT_IDX_CTRL0, 8'h20);
			wr(`EBCT_IDX_CSR, 8'h00);
			chk("ovf kept", {7'h00, irq_o}, 8'h01);
			apb(1'b0, {`EBCT_IDX_CSR, 2'h0}, 8'h00);
			chk("ovf flag", {7'h00, rd[`EBCT_CS_OVF]}, 8'h01);
			wr(`EBCT_IDX_CSR, 8'h00);
			chk("ovf cleared", {7'h00, irq_o}, 8'h00);
			wr(`EBCT_IDX_COUNT, 8'hFC);
			wr(`EBCT_IDX_CTRL0, 8'h01);
			wt(60);
			chk("ovf masked", {7'h00, irq_o}, 8'h00);
			wr(`EBCT_IDX_CTRL0, 8'h00);
			apb(1'b0, {`EBCT_IDX_CSR, 2'h0}, 8'h00);
			chk("ovf flag 2", {7'h00, rd[`EBCT_CS_OVF]}, 8'h01);
			wr(`EBCT_IDX_IRQ, 8'hFF);
			rdc("ovf w1c kept", `EBCT_IDX_IRQ, 8'h20);
			wr(`EBCT_IDX_CSR, 8'h00);
			rdc("ovf cleared 2", `EBCT_IDX_IRQ, 8'h00);
		end
	endtask

	task t_pin;
		reg [47:0] sv;
		reg [5:0]  pe;
		begin
			// a: high, low, high, toggle; then both keep; then b high
			sv = 48'h020102030008;
			pe = 6'h29;
			wr(`EBCT_IDX_CMPA, 8'h02);
			wr(`EBCT_IDX_CMPB, 8'h02);
			for (i = 0; i < 6; i = i + 1) begin
				wr(`EBCT_IDX_CSR, sv[47-8*i -: 8]);
				wr(`EBCT_IDX_COUNT, 8'h00);
				wr(`EBCT_IDX_CTRL0, 8'h01);
				wt(20);
				wr(`EBCT_IDX_CTRL0, 8'h00);
				chk("pin", {7'h00, timer_output_pin_o}, {7'h00, pe[5-i]});
			end
			wr(`EBCT_IDX_CSR, 8'h00);
			wr(`EBCT_IDX_IRQ, 8'hFF);
		end
	endtask

	task t_trig;
		reg [39:0] cfg;
		reg [39:0] ex;
		begin
			cfg = 40'h080C141C04;
			ex = 40'h0003060C0C;
			wr(`EBCT_IDX_COUNT, 8'h00);
			for (i = 0; i < 5; i = i + 1) begin
				wr(`EBCT_IDX_CTRL1, cfg[39-8*i -: 8]);
				repeat (3) begin
					trigger_input_pin_i <= 1'b1;
					wt(6);
					trigger_input_pin_i <= 1'b0;
					wt(6);
				end
				rdc("trigger count", `EBCT_IDX_COUNT, ex[39-8*i -: 8]);
			end
			wr(`EBCT_IDX_CTRL0, 8'h18);
			wr(`EBCT_IDX_CTRL1, 8'h0C);
			trigger_input_pin_i <= 1'b1;
			wt(6);
			trigger_input_pin_i <= 1'b0;
			wt(6);
			rdc("trigger clear", `EBCT_IDX_COUNT, 8'h00);
			wr(`EBCT_IDX_CTRL0, 8'h00);
			wr(`EBCT_IDX_CTRL1, 8'h00);
		end
	endtask

	task t_div;
		begin
			wr(`EBCT_IDX_CTRL1, 8'h01);
			wr(`EBCT_IDX_COUNT, 8'h00);
			wr(`EBCT_IDX_CTRL0, 8'h03);
			wt(600);
			wr(`EBCT_IDX_CTRL0, 8'h00);
			apb(1'b0, {`EBCT_IDX_COUNT, 2'h0}, 8'h00);
			chk("div 128", {7'h00, rd >= 8'h04 && rd <= 8'h05}, 8'h01);
			wr(`EBCT_IDX_CTRL1, 8'h00);
		end
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	initial begin
		reset_n_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 18'h00000;
		pwdata_i = 32'h00000000;
		trigger_input_pin_i = 1'b0;
		failures = 0;
		checks = 0;
		repeat (10) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		@(posedge sys_clk_i);
		t_reset;
		t_flags;
		t_ovf;
		t_pin;
		t_trig;
		t_div;
		tally_and_finish;
	end
endmodule // tb
